// File: design/tmf_top.sv
// four timer units (compact 0, enhanced 1, standard 2, compact 3) with pin
// routing and an interrupt summary, reached over an AHB-Lite slave port.
// assumes all inputs synchronous to clock; tick inputs are one-cycle strobes.
//
// Decided for this implementation: the AHB-Lite interface to the registers and the register offsets.
`include "tmf_defines.svh"
`default_nettype none
module tmf_top (
    input wire logic clock,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic internal_high_tick,
    input wire logic time_base_tick,
    input wire logic [3:0] external_clock_input,
    output logic [3:0] external_clock_taken,
    input wire logic [9:0] port_invert,
    output logic [9:0] timer_output_pin,
    output logic [9:0] timer_output_pin_oe,
    output logic irq
);
    tmf_pkg::tmf_state_t s_reg;
    tmf_pkg::tmf_state_t s_next;

    // pin order: compact0 out0/out1, enhanced A, enhanced B0/B1/B2,
    // standard out0/out1, compact3 out0/out1
    logic [9:0] pin_en;
    logic [9:0] pin_src;
    logic [15:0] wmask;
    logic tick;
    logic hit_a;
    logic hit_b;
    logic hit_p;
    logic clr_hit;
    logic [2:0] sel;
    logic [1:0] act;
    logic ext_edge;
    logic addr_ok;
    logic [4:0] idx;
    logic [4:0] rel;
    logic [1:0] tsel;
    logic [31:0] rd;
    logic [11:0] set_bits;
    logic [11:0] rd_clear;

    function automatic logic apply_act(input logic cur, input logic [1:0] a);
        logic r;
        r = cur;
        unique case (a)
            `TMF_ACT_NONE: r = cur;
            `TMF_ACT_LOW: r = 1'b0;
            `TMF_ACT_HIGH: r = 1'b1;
            `TMF_ACT_TOGGLE: r = ~cur;
        endcase
        return r;
    endfunction

    always_comb begin
        s_next = s_reg;
        set_bits = 12'h000;
        rd_clear = 12'h000;
        tick = 1'b0;
        hit_a = 1'b0;
        hit_b = 1'b0;
        hit_p = 1'b0;
        clr_hit = 1'b0;
        sel = 3'h0;
        act = 2'h0;
        ext_edge = 1'b0;
        wmask = `TMF_MASK_10;
        s_next.prescale = s_reg.prescale + 8'h01;

        for (int i = 0; i < 4; i++) begin
            wmask = (i == `TMF_STD_TIMER) ? `TMF_MASK_16 : `TMF_MASK_10;
            sel = s_reg.ctrl[i][`TMF_CTRL_SEL_HI:`TMF_CTRL_SEL_LO];
            act = s_reg.ctrl[i][`TMF_CTRL_ACT_HI:`TMF_CTRL_ACT_LO];
            ext_edge = s_reg.ctrl[i][`TMF_CTRL_FALL]
                ? (s_reg.ext_prev[i] & ~external_clock_input[i])
                : (~s_reg.ext_prev[i] & external_clock_input[i]);
            s_next.ext_prev[i] = external_clock_input[i];
            s_next.ext_sel[i] = (sel == `TMF_SEL_EXT);
            unique case (sel)
                `TMF_SEL_SYS: tick = 1'b1;
                `TMF_SEL_SYS4: tick = (s_reg.prescale[1:0] == `TMF_PRE_DIV4);
                `TMF_SEL_SYS16: tick = (s_reg.prescale[3:0] == `TMF_PRE_DIV16);
                `TMF_SEL_HIGH: tick = internal_high_tick;
                `TMF_SEL_TBC: tick = time_base_tick;
                `TMF_SEL_RSVD: tick = 1'b0;
                `TMF_SEL_SYS64: tick = (s_reg.prescale[5:0] == `TMF_PRE_DIV64);
                `TMF_SEL_EXT: tick = ext_edge;
            endcase
            tick = tick & s_reg.ctrl[i][`TMF_CTRL_RUN];
            // compare match on the counted edge
            hit_a = tick && (s_reg.cnt[i] == s_reg.cmp_a[i]);
            hit_b = tick && (i == `TMF_ENH_TIMER) && (s_reg.cnt[i] == s_reg.cmp_b[i]);
            hit_p = tick && (s_reg.cnt[i] == s_reg.cmp_p[i]);
            clr_hit = s_reg.ctrl[i][`TMF_CTRL_CLR_A] ? hit_a : hit_p;
            // advance by one per active edge
            if (clr_hit) begin
                s_next.cnt[i] = 16'h0000;
            end else if (tick) begin
                s_next.cnt[i] = (s_reg.cnt[i] + 16'h0001) & wmask;
            end
            // A and P interrupts per timer, B on the enhanced timer only
            set_bits[3 * i + `TMF_ST_A] = hit_a;
            set_bits[3 * i + `TMF_ST_P] = hit_p;
            set_bits[3 * i + `TMF_ST_B] = hit_b;
            if (s_reg.ctrl[i][`TMF_CTRL_PWM]) begin
                // pwm duty below A and B, period set by the P clear, or the A clear when TMF_CTRL_CLR_A is set
                s_next.out_a[i] = (s_next.cnt[i] < s_reg.cmp_a[i]);
                s_next.out_b[i] = (s_next.cnt[i] < s_reg.cmp_b[i]);
            end else begin
                if (hit_a) begin
                    s_next.out_a[i] = apply_act(s_reg.out_a[i], act);
                end
                if (hit_b) begin
                    s_next.out_b[i] = apply_act(s_reg.out_b[i], act);
                end
            end
        end

        // bus address phase decode
        idx = haddr[6:2];
        addr_ok = (haddr[31:7] == `TMF_ADDR_HI_ZERO) && (idx < `TMF_IDX_LIMIT);
        rel = idx - `TMF_IDX_TMR_BASE;
        tsel = rel[3:2];
        rd = 32'h00000000;
        if (addr_ok) begin
            if (idx == `TMF_IDX_PIN_EN0) begin
                rd = {24'h000000, s_reg.pin_en0};
            end else if (idx == `TMF_IDX_PIN_EN1) begin
                rd = {24'h000000, s_reg.pin_en1};
            end else if (idx == `TMF_IDX_STATUS) begin
                rd = {20'h00000, s_reg.status};
            end else if (idx == `TMF_IDX_MASK) begin
                rd = {20'h00000, s_reg.mask};
            end else if (idx >= `TMF_IDX_CNT_BASE) begin
                rd = {16'h0000, s_reg.cnt[idx[1:0]]};
            end else begin
                unique case (rel[1:0])
                    `TMF_SLOT_CTRL: rd = {23'h000000, s_reg.ctrl[tsel]};
                    `TMF_SLOT_CMP_A: rd = {16'h0000, s_reg.cmp_a[tsel]};
                    `TMF_SLOT_CMP_B: rd = {16'h0000, s_reg.cmp_b[tsel]};
                    `TMF_SLOT_CMP_P: rd = {16'h0000, s_reg.cmp_p[tsel]};
                endcase
            end
        end
        s_next.ready = 1'b1;
        s_next.wr_pend = 1'b0;
        if (hsel && hready && htrans[1]) begin
            s_next.wr_pend = hwrite && addr_ok;
            s_next.wr_idx = idx;
            if (!hwrite) begin
                s_next.rdata = rd;
                // status is cleared by its read
                if (addr_ok && idx == `TMF_IDX_STATUS) begin
                    rd_clear = s_reg.status;
                end
            end
        end

        // data phase write
        rel = s_reg.wr_idx - `TMF_IDX_TMR_BASE;
        tsel = rel[3:2];
        wmask = (tsel == 2'(`TMF_STD_TIMER)) ? `TMF_MASK_16 : `TMF_MASK_10;
        if (s_reg.wr_pend) begin
            if (s_reg.wr_idx == `TMF_IDX_PIN_EN0) begin
                s_next.pin_en0 = hwdata[7:0] & `TMF_PE0_WMASK;
            end else if (s_reg.wr_idx == `TMF_IDX_PIN_EN1) begin
                s_next.pin_en1 = hwdata[7:0] & `TMF_PE1_WMASK;
            end else if (s_reg.wr_idx == `TMF_IDX_MASK) begin
                s_next.mask = hwdata[11:0] & (`TMF_ST_WMASK);
            end else if (s_reg.wr_idx >= `TMF_IDX_TMR_BASE
                && s_reg.wr_idx < `TMF_IDX_CNT_BASE) begin
                unique case (rel[1:0])
                    `TMF_SLOT_CTRL: s_next.ctrl[tsel] = hwdata[`TMF_CTRL_W - 1:0];
                    `TMF_SLOT_CMP_A: s_next.cmp_a[tsel] = hwdata[15:0] & wmask;
                    `TMF_SLOT_CMP_B: begin
                        if (tsel == 2'(`TMF_ENH_TIMER)) begin
                            s_next.cmp_b[tsel] = hwdata[15:0] & wmask;
                        end
                    end
                    `TMF_SLOT_CMP_P: s_next.cmp_p[tsel] = hwdata[15:0] & wmask;
                endcase
            end
        end

        // a match in the cycle of a clearing read stays set
        s_next.status = ((s_reg.status & ~rd_clear) | set_bits) & (`TMF_ST_WMASK);
        s_next.irq = |(s_next.status & s_next.mask);

        pin_en = {s_reg.pin_en1[5:4], s_reg.pin_en1[1:0], s_reg.pin_en0[6:4],
            s_reg.pin_en0[7], s_reg.pin_en0[1:0]};
        pin_src = {{2{s_reg.out_a[3]}}, {2{s_reg.out_a[2]}}, {3{s_reg.out_b[1]}},
            s_reg.out_a[1], {2{s_reg.out_a[0]}}};
        // second register drives standard and compact3 pins
        // enable gives the pin to the timer
        s_next.pin_oe = pin_en;
        s_next.pin_val = (pin_src ^ port_invert) & pin_en;
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            s_reg <= '0;
            // reset enables A and output 0 of each timer
            s_reg.pin_en0 <= `TMF_PE0_RESET;
            s_reg.pin_en1 <= `TMF_PE1_RESET;
            s_reg.pin_oe <= `TMF_OE_RESET;
            s_reg.ready <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    assign hreadyout = s_reg.ready;
    assign hresp = 1'b0;
    assign hrdata = s_reg.rdata;
    assign irq = s_reg.irq;
    assign external_clock_taken = s_reg.ext_sel;
    assign timer_output_pin = s_reg.pin_val;
    assign timer_output_pin_oe = s_reg.pin_oe;
endmodule
`default_nettype wire

// File: design/tmf_defines.svh
// constant names for the timer framework: register map, field layout, reset values
// assumes word-aligned AHB-Lite access, 32-bit data
`ifndef TMF_DEFINES_SVH
`define TMF_DEFINES_SVH

// register word indices (byte address = index * 4)
`define TMF_IDX_PIN_EN0 5'h00
`define TMF_IDX_PIN_EN1 5'h01
`define TMF_IDX_STATUS 5'h02
`define TMF_IDX_MASK 5'h03
`define TMF_IDX_TMR_BASE 5'h04
`define TMF_IDX_CNT_BASE 5'h14
`define TMF_IDX_LIMIT 5'h18
`define TMF_ADDR_HI_ZERO 25'h0000000

// per-timer register slot inside its group of four
`define TMF_SLOT_CTRL 2'h0
`define TMF_SLOT_CMP_A 2'h1
`define TMF_SLOT_CMP_B 2'h2
`define TMF_SLOT_CMP_P 2'h3

// control word fields
`define TMF_CTRL_RUN 0
`define TMF_CTRL_SEL_LO 1
`define TMF_CTRL_SEL_HI 3
`define TMF_CTRL_FALL 4
`define TMF_CTRL_CLR_A 5
`define TMF_CTRL_ACT_LO 6
`define TMF_CTRL_ACT_HI 7
`define TMF_CTRL_PWM 8
`define TMF_CTRL_W 9

// clock select codes
`define TMF_SEL_SYS 3'h0
`define TMF_SEL_SYS4 3'h1
`define TMF_SEL_SYS16 3'h2
`define TMF_SEL_HIGH 3'h3
`define TMF_SEL_TBC 3'h4
`define TMF_SEL_RSVD 3'h5
`define TMF_SEL_SYS64 3'h6
`define TMF_SEL_EXT 3'h7
`define TMF_PRE_DIV4 8'h03
`define TMF_PRE_DIV16 8'h0F
`define TMF_PRE_DIV64 8'h3F

// output actions on a compare match
`define TMF_ACT_NONE 2'h0
`define TMF_ACT_LOW 2'h1
`define TMF_ACT_HIGH 2'h2
`define TMF_ACT_TOGGLE 2'h3

// counter widths and which timer is which type
`define TMF_MASK_10 16'h03FF
`define TMF_MASK_16 16'hFFFF
`define TMF_STD_TIMER 2
`define TMF_ENH_TIMER 1

// pin enable registers: writable bits and reset values
`define TMF_PE0_WMASK 8'hF3
`define TMF_PE0_RESET 8'h91
`define TMF_PE1_WMASK 8'h33
`define TMF_PE1_RESET 8'h11

// status bit layout: three bits per timer (A, B, P); B only on the enhanced timer
`define TMF_ST_A 0
`define TMF_ST_B 1
`define TMF_ST_P 2
`define TMF_ST_WMASK 12'hB7D

// output enables implied by the enable reset values, so pins are right from reset
`define TMF_OE_RESET 10'h14D

`endif

// File: design/tmf_pkg.sv
// types shared by the timer framework
// assumes tmf_defines.svh is compiled alongside
`default_nettype none
package tmf_pkg;
    typedef struct packed {
        logic [3:0][15:0] cnt;
        logic [3:0][8:0] ctrl;
        logic [3:0][15:0] cmp_a;
        logic [3:0][15:0] cmp_b;
        logic [3:0][15:0] cmp_p;
        logic [3:0] out_a;
        logic [3:0] out_b;
        logic [3:0] ext_prev;
        logic [3:0] ext_sel;
        logic [7:0] prescale;
        logic [7:0] pin_en0;
        logic [7:0] pin_en1;
        logic [11:0] status;
        logic [11:0] mask;
        logic wr_pend;
        logic [4:0] wr_idx;
        logic [31:0] rdata;
        logic ready;
        logic irq;
        logic [9:0] pin_val;
        logic [9:0] pin_oe;
    } tmf_state_t;
endpackage
`default_nettype wire

// File: sim/tmf_monitor.sv
// checker for the timer framework on the top module's ports
// assumes one slave, so hready is hreadyout fed back
`default_nettype none
module tmf_monitor (
    input wire logic clock,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    input wire logic [9:0] timer_output_pin,
    input wire logic [9:0] timer_output_pin_oe,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 1ps;
    logic rd;
    assign rd = hsel && hready && htrans[1] && !hwrite;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);
    property p_okay;
        hreadyout && !hresp;
    endproperty
    a_okay: assert property (p_okay) else $error("slave stalled or erred");
    property p_rst_pins;
        $past(rst) |-> timer_output_pin_oe == 10'h14D && !irq;
    endproperty
    a_rst_pins: assert property (p_rst_pins) else $error("bad state after reset");
    property p_gated;
        (timer_output_pin & ~timer_output_pin_oe) == 10'h000;
    endproperty
    a_gated: assert property (p_gated) else $error("disabled pin driven");
    property p_hold;
        !rd |=> $stable(hrdata);
    endproperty
    a_hold: assert property (p_hold) else $error("read data moved without a read");
    property p_unmapped;
        rd && (haddr[31:7] != 25'h0 || haddr[6:2] >= 5'h18) |=> hrdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_pe0;
        rd && haddr == 32'h0 |=> (hrdata & 32'hFFFFFF0C) == 32'h0;
    endproperty
    a_pe0: assert property (p_pe0) else $error("enable 0 spare bits set");
    property p_pe1;
        rd && haddr == 32'h4 |=> (hrdata & 32'hFFFFFFCC) == 32'h0;
    endproperty
    a_pe1: assert property (p_pe1) else $error("enable 1 spare bits set");
    property p_stat;
        rd && haddr[31:3] == 29'h1 |=> (hrdata & 32'hFFFFF482) == 32'h0;
    endproperty
    a_stat: assert property (p_stat) else $error("absent interrupt bit set");
endmodule
bind tmf_top tmf_monitor mon (.clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .timer_output_pin(timer_output_pin),
    .timer_output_pin_oe(timer_output_pin_oe), .irq(irq));
`default_nettype wire

// File: sim/tmf_far_side.sv
// far side: external clock pins and the strobes of the other clock sources
// assumes mode changes just after a rising edge
`default_nettype none
module tmf_far_side (
    input wire logic clock,
    input wire logic [2:0] mode,
    output logic internal_high_tick,
    output logic time_base_tick,
    output logic [3:0] external_clock_input
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] ph = 3'h0;
    logic [1:0] tk = 2'h0;
    logic [3:0] ext = 4'h0;
    assign internal_high_tick = tk[0];
    assign time_base_tick = tk[1];
    assign external_clock_input = ext;
    // one pin swings both ways, still outside runs
    always @(posedge clock) begin
        ph <= ph + 3'h1;
        tk <= (ph == 3'h7) ? mode[1:0] : 2'h0;
        if (mode[2] && ph == 3'h7) begin
            ext <= {3'h0, ~ext[0]};
        end
    end
endmodule
`default_nettype wire

// File: sim/tb_timer_module_common_framework.sv
// bench for the timer framework: registers, clock sources, compare matches
// assumes tmf_top, tmf_far_side and the bound checker are compiled first
`default_nettype none
module tb_timer_module_common_framework;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock, rst, hsel, hwrite, hreadyout, hresp, irq, iht, tbt;
    logic [1:0] htrans;
    logic [2:0] hsize, mode, sel;
    logic [31:0] haddr, hwdata, hrdata, rd, c0, diff, seed;
    logic [3:0] ext_in, ext_taken;
    logic [9:0] port_invert, pin, pin_oe;
    int n_errors, n_checks, tol;
    int nom[8] = '{66, 16, 4, 8, 8, 0, 1, 4};
    tmf_top uut (.clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .internal_high_tick(iht),
        .time_base_tick(tbt), .external_clock_input(ext_in), .external_clock_taken(ext_taken),
        .port_invert(port_invert), .timer_output_pin(pin), .timer_output_pin_oe(pin_oe),
        .irq(irq));
    tmf_far_side far (.clock(clock), .mode(mode), .internal_high_tick(iht),
        .time_base_tick(tbt), .external_clock_input(ext_in));
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return (x >> 1) ^ (x[0] ? 32'h80200003 : 32'h0);
    endfunction
    function automatic logic [9:0] oe_of(input logic [7:0] e0, input logic [7:0] e1);
        return {e1[5], e1[4], e1[1], e1[0], e0[6], e0[5], e0[4], e0[7], e0[1], e0[0]};
    endfunction
    task automatic wrap_up();
        $display("errors %0d checks %0d", n_errors, n_checks);
        if (n_errors == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // pin enables reach the pin outputs a cycle after the write lands, so writes add an idle cycle
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        do @(posedge clock); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clock); while (hreadyout !== 1'b1);
        rd = hrdata;
        if (wr) @(posedge clock);
    endtask
    task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    initial begin
        repeat (20000) @(posedge clock);
        n_errors++;
        wrap_up();
    end
    initial begin
        {rst, hsel, hwrite, htrans, haddr, hwdata} = {1'b1, 1'b1, 1'b0, 2'h0, 64'h0};
        {hsize, mode, port_invert, seed} = {3'h2, 3'h0, 10'h0, 32'hD6F4};
        n_errors = 0;
        n_checks = 0;
        repeat (12) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        chk({22'h0, pin_oe}, 32'h14D);
        rdchk(32'h0, 32'h91);
        rdchk(32'h4, 32'h11);
        bus(1'b1, 32'h60, 32'hFFFF);
        rdchk(32'h60, 32'h0);
        for (int i = 0; i < 6; i++) begin
            seed = lfsr(lfsr(lfsr(seed)));
            port_invert <= seed[25:16];
            bus(1'b1, 32'h0, seed);
            bus(1'b1, 32'h4, {24'h0, seed[15:8]});
            rdchk(32'h0, seed & 32'hF3);
            rdchk(32'h4, {24'h0, seed[15:8] & 8'h33});
            chk({22'h0, pin_oe}, {22'h0, oe_of(seed[7:0], seed[15:8])});
        end
        bus(1'b1, 32'h14, 32'h3FF);
        bus(1'b1, 32'h1C, 32'h3FF);
        // every select code once, the external pin on both edges
        for (int i = 0; i < 9; i++) begin
            sel = (i == 8) ? 3'h7 : i[2:0];
            tol = (sel == 3'h0 || sel == 3'h5) ? 0 : 1;
            mode <= {sel == 3'h7, sel == 3'h4, sel == 3'h3};
            bus(1'b1, 32'h10, {27'h0, i == 8, sel, 1'b1});
            @(posedge clock);
            chk({31'h0, ext_taken[0]}, {31'h0, sel == 3'h7});
            bus(1'b0, 32'h50, 32'h0);
            c0 = rd;
            repeat (64) @(posedge clock);
            bus(1'b0, 32'h50, 32'h0);
            diff = (rd - c0) & 32'h3FF;
            chk({31'h0, diff >= nom[sel] - tol && diff <= nom[sel] + tol}, 32'h1);
        end
        mode <= 3'h0;
        port_invert <= seed[9:0];
        bus(1'b1, 32'h10, 32'h0);
        bus(1'b1, 32'h0, 32'hFF);
        bus(1'b1, 32'h4, 32'hFF);
        bus(1'b1, 32'hC, 32'h0);
        bus(1'b1, 32'h18, 32'h55);
        rdchk(32'h18, 32'h0);
        bus(1'b1, 32'h14, 32'h10);
        bus(1'b1, 32'h1C, 32'h20);
        bus(1'b1, 32'h24, 32'h10);
        bus(1'b1, 32'h28, 32'h18);
        bus(1'b1, 32'h2C, 32'h20);
        bus(1'b1, 32'h10, 32'h81);
        bus(1'b1, 32'h20, 32'h81);
        repeat (1100) @(posedge clock);
        chk({31'h0, irq}, 32'h0);
        bus(1'b1, 32'hC, 32'hFFF);
        rdchk(32'hC, 32'hB7D);
        @(posedge clock);
        chk({31'h0, irq}, 32'h1);
        bus(1'b1, 32'h10, 32'h0);
        bus(1'b1, 32'h20, 32'h0);
        chk({22'h0, pin}, {22'h0, port_invert ^ 10'h03F});
        bus(1'b1, 32'h40, 32'h100);
        repeat (2) @(posedge clock);
        chk({30'h0, pin[9:8]}, {30'h0, port_invert[9:8]});
        bus(1'b1, 32'h44, 32'h3FF);
        repeat (2) @(posedge clock);
        chk({30'h0, pin[9:8]}, {30'h0, ~port_invert[9:8]});
        rdchk(32'h8, 32'h3D);
        rdchk(32'h8, 32'h0);
        repeat (2) @(posedge clock);
        chk({31'h0, irq}, 32'h0);
        wrap_up();
    end
endmodule
`default_nettype wire
